// ===== idmm_pkg.sv
// idmm_pkg: constants and carrier types for the memory map decoder
// assumes: used by idmm_top, idmm_ram and the testbench, referenced with package::name
package idmm_pkg;
  // ==========================================================
  // program space
  localparam logic [15:0] PROG_TOP_64K = 16'hffff;
  localparam logic [15:0] PROG_TOP_32K = 16'h7fff;
  localparam logic [15:0] LOCK_64K = 16'hfbff;
  localparam logic [15:0] LOCK_32K = 16'h7fff;
  localparam logic [15:0] RSVD_ABOVE_64K = 16'hfdff;
  // ==========================================================
  // data space
  localparam int IRAM_BYTES = 256;
  localparam int XRAM_BYTES = 4096;
  localparam logic [7:0] LOWER_TOP = 8'h7f;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam int BANK_LO_BIT = 3;
  localparam int BANK_HI_BIT = 4;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] SP_STEP = 8'h01;

  // data access kinds
  typedef enum logic [2:0] {
    ACC_NONE = 3'b000,
    ACC_DIRECT = 3'b001,
    ACC_INDIRECT = 3'b010,
    ACC_BIT = 3'b011,
    ACC_REG = 3'b100,
    ACC_PUSH = 3'b101,
    ACC_POP = 3'b110
  } idmm_acc_t;

  // program / xdata access kinds
  typedef enum logic [1:0] {
    PACC_NONE = 2'b00,
    PACC_MOVC = 2'b01,
    PACC_XRD = 2'b10,
    PACC_XWR = 2'b11
  } idmm_pacc_t;

  // internal data request from the core
  typedef struct packed {
    idmm_acc_t kind;
    logic wr;
    logic [7:0] addr;
    logic [2:0] rn;
    logic [7:0] wdata;
    logic bit_wdata;
  } idmm_dreq_t;

  // program / xdata request from the core
  typedef struct packed {
    idmm_pacc_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } idmm_preq_t;
endpackage : idmm_pkg

// ===== idmm_ram.sv
// idmm_ram: single write port flip-flop memory with async read
// assumes: one clock, async active low reset clears contents
module idmm_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clock, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write index
  input wire logic [7:0] wdata, // write byte
  input wire logic [AW-1:0] raddr, // read index
  output logic [7:0] rdata // read byte, combinational
);
  logic [7:0] mem_ff [DEPTH];

  // ==========================================================
  // storage
  assign rdata = mem_ff[raddr];

  // cleared at reset so simulation never reads unknown bytes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= idmm_pkg::BYTE_ZERO;
      end
    end else if (we) begin
      mem_ff[waddr] <= wdata;
    end
  end
endmodule : idmm_ram

// ===== idmm_top.sv
// idmm_top: internal data and program memory map of an 8-bit core
// assumes: core issues one request per cycle, answers registered
// Functional notes
// [RULE1] flash is one contiguous range, to 0xffff or 0x7fff by variant
// [RULE2] lock byte sits at 0xfbff or 0x7fff by variant
// [RULE3] 64 kB variant marks addresses above 0xfdff reserved
// [RULE4] movc reads flash; xdata writes go to flash when enabled
// [RULE5] without redirection xdata reads and writes reach on-chip xram
// [RULE6] 256 bytes internal plus 4096 bytes xram
// [RULE7] lower 128 bytes reachable directly and indirectly
// [RULE8] 0x00-0x1f are four banks of r0-r7, chosen by psw bits 3,4
// [RULE9] indirect pointer comes from r0 or r1 of active bank
// [RULE10] bytes 0x20-0x2f form bit addresses 0x00-0x7f ascending
// [RULE11] bit address is eight times byte offset plus bit position
// [RULE12] bit or byte access chosen by operand type, not address
// [RULE13] upper 128 bytes only indirect, separate from sfr space
// [RULE14] direct above 0x7f goes to sfr, indirect to upper ram
// [RULE15] push increments pointer first, then writes new location
// [RULE16] reset loads stack pointer 0x07; first push lands at 0x08
// [RULE17] stack may sit anywhere in 256 bytes, depth up to 256
// [RULE18] rn address is eight times bank plus n
// [RULE19] push and pop reach ram indirectly, never sfr
module idmm_top #(
  parameter bit BIG_FLASH = 1'b1, // 1: 64 kB variant, 0: 32 kB
  parameter int XRAM_AW = 12
) (
  input wire logic clock, // system clock, 200 MHz
  input wire logic reset_n, // async reset, active low
  input wire idmm_pkg::idmm_dreq_t dreq, // internal data request
  input wire logic [7:0] psw, // program status word from core
  input wire logic sp_load, // core writes stack pointer
  input wire logic [7:0] sp_wdata, // new stack pointer value
  input wire idmm_pkg::idmm_preq_t preq, // program or xdata request
  input wire logic flash_wr_en, // xdata writes go to flash
  input wire logic [7:0] flash_rdata, // byte from flash array
  output logic [7:0] drdata_ff, // internal data read byte
  output logic bit_rdata_ff, // bit read value
  output logic sfr_sel_ff, // request went to sfr space
  output logic [7:0] sfr_addr_ff, // sfr address for core
  output logic sfr_wr_ff, // sfr write pulse
  output logic [7:0] sfr_wdata_ff, // sfr write data
  output logic [7:0] sp_ff, // stack pointer
  output logic [15:0] flash_addr_ff, // flash address
  output logic flash_rd_ff, // flash read pulse
  output logic flash_wr_ff, // flash write or erase pulse
  output logic [7:0] flash_wdata_ff, // flash write byte
  output logic lock_hit_ff, // access hit lock byte
  output logic rsvd_hit_ff, // access hit reserved or absent area
  output logic [7:0] prdata_ff // movc or xdata read byte
);
  // ==========================================================
  // shared arithmetic
  function automatic logic [7:0] reg_addr(input logic [7:0] p,
                                           input logic [2:0] n);
    reg_addr = {3'h0, p[idmm_pkg::BANK_HI_BIT], // RULE18
                p[idmm_pkg::BANK_LO_BIT], n};
  endfunction : reg_addr

  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    bit_byte = idmm_pkg::BIT_BASE + {4'h0, b[6:3]}; // RULE11
  endfunction : bit_byte

  // ==========================================================
  // internal data decode
  idmm_pkg::idmm_acc_t kind;
  logic bank_select_low;
  logic bank_select_high;
  logic [1:0] bank_num;
  logic [7:0] ptr_addr;
  logic [7:0] ptr_val;
  logic [7:0] rn_addr;
  logic [7:0] bit_addr;
  logic [7:0] sp_inc;
  logic to_sfr;
  logic [7:0] ram_addr;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [7:0] ptr_rdata;
  logic bit_old;
  logic [7:0] bit_merged;

  // bank bits straight from psw; the core owns psw
  assign kind = dreq.kind;
  assign bank_select_low = psw[idmm_pkg::BANK_LO_BIT]; // RULE8
  assign bank_select_high = psw[idmm_pkg::BANK_HI_BIT]; // RULE8
  assign bank_num = {bank_select_high, bank_select_low};
  assign rn_addr = reg_addr(psw, dreq.rn); // RULE18
  // pointer is r0 or r1 of the active bank
  assign ptr_addr = reg_addr(psw, {2'b00, dreq.rn[0]}); // RULE9
  assign ptr_val = ptr_rdata;
  assign bit_addr = bit_byte(dreq.addr); // RULE10
  assign sp_inc = sp_ff + idmm_pkg::SP_STEP; // RULE17
  // sfr only for direct/bit above 0x7f; operand type picks bit mode
  assign to_sfr = ((kind == idmm_pkg::ACC_DIRECT) ||
                   (kind == idmm_pkg::ACC_BIT)) &&
                  (dreq.addr > idmm_pkg::LOWER_TOP); // RULE14

  // ram address by access mode; stack uses indirect path
  assign ram_addr =
    (kind == idmm_pkg::ACC_REG) ? rn_addr :
    (kind == idmm_pkg::ACC_INDIRECT) ? ptr_val : // RULE13
    (kind == idmm_pkg::ACC_BIT) ? bit_addr : // RULE12
    (kind == idmm_pkg::ACC_PUSH) ? sp_inc : // RULE15
    (kind == idmm_pkg::ACC_POP) ? sp_ff : // RULE19
    dreq.addr; // RULE7

  // bit write is read-modify-write of the containing byte
  assign bit_old = ram_rdata[dreq.addr[2:0]];
  always_comb begin
    bit_merged = ram_rdata;
    bit_merged[dreq.addr[2:0]] = dreq.bit_wdata; // RULE11
  end
  assign ram_wdata = (kind == idmm_pkg::ACC_BIT) ? bit_merged :
                     dreq.wdata;
  assign ram_we = !to_sfr && (kind != idmm_pkg::ACC_NONE) &&
                  (kind != idmm_pkg::ACC_POP) &&
                  (dreq.wr || (kind == idmm_pkg::ACC_PUSH));

  // 256 bytes, one array for lower and upper halves
  idmm_ram #(
    .DEPTH(idmm_pkg::IRAM_BYTES),
    .AW(8)
  ) u_iram (
    .clock(clock),
    .reset_n(reset_n),
    .we(ram_we),
    .waddr(ram_addr),
    .wdata(ram_wdata),
    .raddr(ram_addr),
    .rdata(ram_rdata)
  ); // RULE6

  // second read port for the pointer register, separate copy of the same bytes
  // kept as a mirror so indirect access needs one cycle only
  logic [7:0] iram_shadow_ff [idmm_pkg::IRAM_BYTES];
  assign ptr_rdata = iram_shadow_ff[ptr_addr];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < idmm_pkg::IRAM_BYTES; i++) begin
        iram_shadow_ff[i] <= idmm_pkg::BYTE_ZERO;
      end
    end else if (ram_we) begin
      iram_shadow_ff[ram_addr] <= ram_wdata;
    end
  end

  // ==========================================================
  // stack pointer
  logic [7:0] nxt_sp;
  assign nxt_sp = sp_load ? sp_wdata :
                  (kind == idmm_pkg::ACC_PUSH) ? sp_inc : // RULE15
                  (kind == idmm_pkg::ACC_POP) ? sp_ff - idmm_pkg::SP_STEP :
                  sp_ff;

  // reset value puts the first push at r0 of bank 1
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sp_ff <= idmm_pkg::SP_RESET; // RULE16
    end else begin
      sp_ff <= nxt_sp; // RULE17
    end
  end

  // ==========================================================
  // internal data answers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drdata_ff <= idmm_pkg::BYTE_ZERO;
      bit_rdata_ff <= 1'b0;
      sfr_sel_ff <= 1'b0;
      sfr_addr_ff <= idmm_pkg::BYTE_ZERO;
      sfr_wr_ff <= 1'b0;
      sfr_wdata_ff <= idmm_pkg::BYTE_ZERO;
    end else begin
      drdata_ff <= ram_rdata;
      bit_rdata_ff <= bit_old;
      sfr_sel_ff <= to_sfr; // RULE14
      sfr_addr_ff <= dreq.addr;
      sfr_wr_ff <= to_sfr && dreq.wr;
      sfr_wdata_ff <= dreq.wdata;
    end
  end

  // ==========================================================
  // program space and xdata decode
  logic [15:0] prog_top;
  logic [15:0] lock_addr;
  logic in_flash;
  logic is_lock;
  logic is_rsvd;
  logic movc;
  logic x_to_flash;
  logic x_rd;
  logic x_wr;
  logic [7:0] xram_rdata;

  assign prog_top = BIG_FLASH ? idmm_pkg::PROG_TOP_64K :
                    idmm_pkg::PROG_TOP_32K;
  assign lock_addr = BIG_FLASH ? idmm_pkg::LOCK_64K :
                     idmm_pkg::LOCK_32K;
  assign in_flash = preq.addr <= prog_top; // RULE1
  assign is_lock = preq.addr == lock_addr; // RULE2
  // reserved tail of the big part, or past the end of the small one
  assign is_rsvd = (BIG_FLASH && (preq.addr > idmm_pkg::RSVD_ABOVE_64K))
                   || !in_flash; // RULE3
  assign movc = preq.kind == idmm_pkg::PACC_MOVC; // RULE4
  assign x_to_flash = (preq.kind == idmm_pkg::PACC_XWR) &&
                      flash_wr_en; // RULE4
  assign x_rd = preq.kind == idmm_pkg::PACC_XRD; // RULE5
  assign x_wr = (preq.kind == idmm_pkg::PACC_XWR) && !flash_wr_en;

  // xram aliases over the low address bits
  idmm_ram #(
    .DEPTH(idmm_pkg::XRAM_BYTES),
    .AW(XRAM_AW)
  ) u_xram (
    .clock(clock),
    .reset_n(reset_n),
    .we(x_wr), // RULE5
    .waddr(preq.addr[XRAM_AW-1:0]),
    .wdata(preq.wdata),
    .raddr(preq.addr[XRAM_AW-1:0]),
    .rdata(xram_rdata)
  ); // RULE6

  // reserved addresses never reach the array
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_addr_ff <= 16'h0000;
      flash_rd_ff <= 1'b0;
      flash_wr_ff <= 1'b0;
      flash_wdata_ff <= idmm_pkg::BYTE_ZERO;
      lock_hit_ff <= 1'b0;
      rsvd_hit_ff <= 1'b0;
    end else begin
      flash_addr_ff <= preq.addr;
      flash_rd_ff <= movc && !is_rsvd; // RULE4
      flash_wr_ff <= x_to_flash && !is_rsvd; // RULE3
      flash_wdata_ff <= preq.wdata;
      lock_hit_ff <= (movc || x_to_flash) && is_lock; // RULE2
      rsvd_hit_ff <= (movc || x_to_flash) && is_rsvd; // RULE3
    end
  end

  // movc data comes a cycle after flash_rd_ff; xdata read is local
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= idmm_pkg::BYTE_ZERO;
    end else if (x_rd) begin
      prdata_ff <= xram_rdata; // RULE5
    end else if (flash_rd_ff) begin
      prdata_ff <= flash_rdata;
    end
  end

  // ==========================================================
  // checks
  // stack pointer and stack addressing; reset value is seen at release
  sp_reset_a: assert property (@(posedge clock) // RULE16
    $rose(reset_n) |-> sp_ff == idmm_pkg::SP_RESET)
    else $error("stack pointer not 0x07 after reset");
  push_inc_a: assert property ( // RULE15
    @(posedge clock) disable iff (!reset_n)
    (kind == idmm_pkg::ACC_PUSH && !sp_load) |=>
      sp_ff == $past(sp_ff) + idmm_pkg::SP_STEP)
    else $error("push did not increment stack pointer");
  push_addr_a: assert property ( // RULE19
    @(posedge clock) disable iff (!reset_n)
    kind == idmm_pkg::ACC_PUSH |-> ram_we && ram_addr == sp_inc)
    else $error("push wrote wrong location");
  pop_addr_a: assert property ( // RULE19
    @(posedge clock) disable iff (!reset_n)
    kind == idmm_pkg::ACC_POP |-> !ram_we && !to_sfr && ram_addr == sp_ff)
    else $error("pop touched the wrong location");
  pop_dec_a: assert property ( // RULE17
    @(posedge clock) disable iff (!reset_n)
    (kind == idmm_pkg::ACC_POP && !sp_load) |=>
      sp_ff == $past(sp_ff) - idmm_pkg::SP_STEP)
    else $error("pop did not decrement stack pointer");
  sp_load_a: assert property ( // RULE17
    @(posedge clock) disable iff (!reset_n)
    sp_load |=> sp_ff == $past(sp_wdata))
    else $error("stack pointer load lost");

  // data space routing by addressing mode
  direct_sfr_a: assert property ( // RULE14
    @(posedge clock) disable iff (!reset_n)
    (kind == idmm_pkg::ACC_DIRECT && dreq.addr[7]) |=>
      sfr_sel_ff)
    else $error("direct high access missed sfr");
  indir_ram_a: assert property ( // RULE13
    @(posedge clock) disable iff (!reset_n)
    kind == idmm_pkg::ACC_INDIRECT |=> !sfr_sel_ff)
    else $error("indirect access went to sfr");
  high_sfr_a: assert property ( // RULE13
    @(posedge clock) disable iff (!reset_n)
    to_sfr |-> !ram_we)
    else $error("sfr access wrote internal ram");
  reg_bank_a: assert property ( // RULE8
    @(posedge clock) disable iff (!reset_n)
    kind == idmm_pkg::ACC_REG |->
      ram_addr == {3'h0, bank_num, dreq.rn})
    else $error("register bank address wrong");
  indir_ptr_a: assert property ( // RULE9
    @(posedge clock) disable iff (!reset_n)
    kind == idmm_pkg::ACC_INDIRECT |->
      ptr_addr == {3'h0, bank_num, 2'b00, dreq.rn[0]})
    else $error("pointer not r0 or r1 of active bank");
  bit_map_a: assert property ( // RULE10
    @(posedge clock) disable iff (!reset_n)
    (kind == idmm_pkg::ACC_BIT && !dreq.addr[7]) |->
      ram_addr[7:4] == 4'h2 && ram_addr[3:0] == dreq.addr[6:3])
    else $error("bit address maps to wrong byte");
  bit_merge_a: assert property ( // RULE11
    @(posedge clock) disable iff (!reset_n)
    (kind == idmm_pkg::ACC_BIT && !to_sfr) |->
      (ram_wdata[dreq.addr[2:0]] == dreq.bit_wdata) &&
      ((ram_wdata ^ ram_rdata) & ~(8'h01 << dreq.addr[2:0])) == 8'h00)
    else $error("bit write disturbed its neighbours");

  // program space and xdata
  xwr_route_a: assert property ( // RULE5
    @(posedge clock) disable iff (!reset_n)
    (preq.kind == idmm_pkg::PACC_XWR && !flash_wr_en) |=>
      !flash_wr_ff)
    else $error("xdata write leaked to flash");
  xrd_data_a: assert property ( // RULE5
    @(posedge clock) disable iff (!reset_n)
    x_rd |=> !flash_rd_ff && prdata_ff == $past(xram_rdata))
    else $error("xdata read did not return xram byte");
  movc_strobe_a: assert property ( // RULE4
    @(posedge clock) disable iff (!reset_n)
    (movc && !is_rsvd) |=>
      flash_rd_ff && !flash_wr_ff && flash_addr_ff == $past(preq.addr))
    else $error("movc did not reach flash");
  xwr_flash_a: assert property ( // RULE4
    @(posedge clock) disable iff (!reset_n)
    (x_to_flash && !is_rsvd) |=>
      flash_wr_ff && !flash_rd_ff && flash_wdata_ff == $past(preq.wdata))
    else $error("redirected xdata write missed flash");
  rsvd_block_a: assert property ( // RULE3
    @(posedge clock) disable iff (!reset_n)
    (BIG_FLASH && movc && preq.addr > idmm_pkg::RSVD_ABOVE_64K) |=>
      !flash_rd_ff && rsvd_hit_ff)
    else $error("reserved flash read not blocked");
  lock_flag_a: assert property ( // RULE2
    @(posedge clock) disable iff (!reset_n)
    (movc && preq.addr == lock_addr) |=> lock_hit_ff)
    else $error("lock byte access not flagged");
  flash_range_a: assert property ( // RULE1
    @(posedge clock) disable iff (!reset_n)
    flash_rd_ff |-> flash_addr_ff <= prog_top)
    else $error("flash read outside array");
endmodule : idmm_top

// ===== idmm_flash_model.sv
// idmm_flash_model: behavioural flash array behind the decoder
// assumes: the array answers in the cycle its read strobe is high
module idmm_flash_model (
  input wire logic clock, // system clock
  input wire logic [15:0] flash_addr_ff, // address from decoder
  input wire logic flash_rd_ff, // read strobe from decoder
  output logic [7:0] flash_rdata // byte back to decoder
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_ff = 8'h00;
  // ==========================================================
  // array contents
  // data is valid only with the strobe; otherwise the inverse of the
  // last answer shows, so a late or early latch never looks right
  assign flash_rdata = flash_rd_ff ? (flash_addr_ff[7:0] ^ 8'h5a) : ~last_ff;
  // remember the last answer for the released state
  always_ff @(posedge clock) begin
    if (flash_rd_ff) last_ff <= flash_addr_ff[7:0] ^ 8'h5a;
  end
endmodule : idmm_flash_model

// ===== test_internal_data_memory_map.sv
// test_internal_data_memory_map: self-checking bench for idmm_top
// assumes: idmm_pkg compiled first; flash answered by idmm_flash_model
module test_internal_data_memory_map;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    idmm_pkg::idmm_acc_t k;
    logic wr;
    logic [7:0] a, wd, ed;
    logic [2:0] rn;
    logic bw, eb, es, cd;
    logic [1:0] bk;
  } idmm_row_t;
  logic clock, reset_n, sp_load, flash_wr_en;
  logic [7:0] psw, sp_wdata, flash_rdata, drdata_ff, sfr_addr_ff;
  logic [7:0] sfr_wdata_ff, sp_ff, flash_wdata_ff, prdata_ff;
  logic bit_rdata_ff, sfr_sel_ff, sfr_wr_ff, flash_rd_ff, flash_wr_ff;
  logic lock_hit_ff, rsvd_hit_ff;
  logic [15:0] flash_addr_ff;
  wire [3:0] f32; // rd, wr, lock, reserved of the 32 kB variant
  idmm_pkg::idmm_dreq_t dreq, d0;
  idmm_pkg::idmm_preq_t preq, p0;
  int num_errors = 0;
  int num_checks = 0;
  // rows: kind, wr, addr, wdata, exp byte, rn, bit wdata, exp bit,
  // exp sfr, check byte, bank
  idmm_row_t rows [17] = '{
    '{idmm_pkg::ACC_DIRECT, 1, 8'h30, 8'ha5, 8'h00, 0, 0, 0, 0, 0, 0},
    '{idmm_pkg::ACC_DIRECT, 0, 8'h30, 8'h00, 8'ha5, 0, 0, 0, 0, 1, 0},
    '{idmm_pkg::ACC_REG, 1, 8'h00, 8'h90, 8'h00, 1, 0, 0, 0, 0, 2},
    '{idmm_pkg::ACC_INDIRECT, 1, 8'h00, 8'h3c, 8'h00, 1, 0, 0, 0, 0, 2},
    '{idmm_pkg::ACC_DIRECT, 0, 8'h90, 8'h00, 8'h00, 0, 0, 0, 1, 0, 2},
    '{idmm_pkg::ACC_DIRECT, 1, 8'h90, 8'hff, 8'h00, 0, 0, 0, 1, 0, 2},
    '{idmm_pkg::ACC_INDIRECT, 0, 8'h00, 8'h00, 8'h3c, 1, 0, 0, 0, 1, 2},
    '{idmm_pkg::ACC_DIRECT, 0, 8'h11, 8'h00, 8'h90, 0, 0, 0, 0, 1, 0},
    '{idmm_pkg::ACC_REG, 0, 8'h00, 8'h00, 8'h00, 1, 0, 0, 0, 1, 0},
    '{idmm_pkg::ACC_BIT, 1, 8'h13, 8'h00, 8'h00, 0, 1, 0, 0, 0, 0},
    '{idmm_pkg::ACC_DIRECT, 0, 8'h22, 8'h00, 8'h08, 0, 0, 0, 0, 1, 0},
    '{idmm_pkg::ACC_BIT, 0, 8'h13, 8'h00, 8'h08, 0, 0, 1, 0, 0, 0},
    '{idmm_pkg::ACC_DIRECT, 0, 8'h13, 8'h00, 8'h00, 0, 0, 0, 0, 1, 0},
    '{idmm_pkg::ACC_BIT, 1, 8'h7f, 8'h00, 8'h00, 0, 1, 0, 0, 0, 0},
    '{idmm_pkg::ACC_DIRECT, 0, 8'h2f, 8'h00, 8'h80, 0, 0, 0, 0, 1, 0},
    '{idmm_pkg::ACC_BIT, 0, 8'h93, 8'h00, 8'h00, 0, 0, 0, 1, 0, 0},
    '{idmm_pkg::ACC_INDIRECT, 0, 8'h00, 8'h00, 8'h00, 0, 0, 0, 0, 1, 1}
  };
  idmm_top #(.BIG_FLASH(1'b1), .XRAM_AW(12)) u_dut (.clock(clock),
    .reset_n(reset_n), .dreq(dreq), .psw(psw), .sp_load(sp_load),
    .sp_wdata(sp_wdata), .preq(preq), .flash_wr_en(flash_wr_en),
    .flash_rdata(flash_rdata), .drdata_ff(drdata_ff),
    .bit_rdata_ff(bit_rdata_ff), .sfr_sel_ff(sfr_sel_ff),
    .sfr_addr_ff(sfr_addr_ff), .sfr_wr_ff(sfr_wr_ff),
    .sfr_wdata_ff(sfr_wdata_ff), .sp_ff(sp_ff),
    .flash_addr_ff(flash_addr_ff), .flash_rd_ff(flash_rd_ff),
    .flash_wr_ff(flash_wr_ff), .flash_wdata_ff(flash_wdata_ff),
    .lock_hit_ff(lock_hit_ff), .rsvd_hit_ff(rsvd_hit_ff),
    .prdata_ff(prdata_ff));
  // second decoder in the small flash variant, same requests
  idmm_top #(.BIG_FLASH(1'b0), .XRAM_AW(12)) u_dut32 (.clock(clock),
    .reset_n(reset_n), .dreq(dreq), .psw(psw), .sp_load(sp_load),
    .sp_wdata(sp_wdata), .preq(preq), .flash_wr_en(flash_wr_en),
    .flash_rdata(flash_rdata), .drdata_ff(), .bit_rdata_ff(),
    .sfr_sel_ff(), .sfr_addr_ff(), .sfr_wr_ff(), .sfr_wdata_ff(),
    .sp_ff(), .flash_addr_ff(), .flash_rd_ff(f32[3]),
    .flash_wr_ff(f32[2]), .flash_wdata_ff(), .lock_hit_ff(f32[1]),
    .rsvd_hit_ff(f32[0]), .prdata_ff());
  idmm_flash_model u_flash (.clock(clock), .flash_addr_ff(flash_addr_ff),
    .flash_rd_ff(flash_rd_ff), .flash_rdata(flash_rdata));
  // ==========================================================
  // helpers
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // drive one request just after an edge, sample its answer one edge on
  task automatic issue(input idmm_pkg::idmm_dreq_t d,
                       input idmm_pkg::idmm_preq_t p);
    dreq = d;
    preq = p;
    @(posedge clock);
    #1;
  endtask : issue
  function automatic idmm_pkg::idmm_dreq_t dq(idmm_pkg::idmm_acc_t k,
                                              logic [7:0] a, logic [7:0] w);
    return '{k, 1'b0, a, 3'h0, w, 1'b0};
  endfunction : dq
  // flags in order: read strobe, write strobe, lock, reserved
  task automatic pq(input idmm_pkg::idmm_pacc_t k, input logic [15:0] a,
                    input logic [7:0] w, input logic [3:0] e);
    issue(d0, '{k, a, w});
    chk({12'h000, flash_rd_ff, flash_wr_ff, lock_hit_ff, rsvd_hit_ff},
        {12'h000, e});
  endtask : pq
  // ==========================================================
  // clock and watchdog
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #5000;
    num_errors++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    d0 = '{idmm_pkg::ACC_NONE, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0};
    p0 = '{idmm_pkg::PACC_NONE, 16'h0000, 8'h00};
    {dreq, preq, reset_n, sp_load, sp_wdata, flash_wr_en} = '0;
    psw = 8'h00;
    repeat (3) @(posedge clock);
    #1;
    chk({8'h00, sp_ff}, 16'h0007);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      psw = {3'h0, rows[i].bk, 3'h0};
      issue('{rows[i].k, rows[i].wr, rows[i].a, rows[i].rn, rows[i].wd,
              rows[i].bw}, p0);
      chk({14'h0, sfr_sel_ff, sfr_wr_ff},
          {14'h0, rows[i].es, rows[i].es & rows[i].wr});
      if (rows[i].es) chk({sfr_addr_ff, sfr_wdata_ff},
                          {rows[i].a, rows[i].wd});
      if (rows[i].cd) chk({8'h00, drdata_ff}, {8'h00, rows[i].ed});
      if (rows[i].k == idmm_pkg::ACC_BIT && !rows[i].wr && !rows[i].es)
        chk({15'h0, bit_rdata_ff}, {15'h0, rows[i].eb});
    end
    psw = 8'h00;
    // first push after reset lands in bank 1 r0
    issue(dq(idmm_pkg::ACC_PUSH, 8'h00, 8'h55), p0);
    chk({8'h00, sp_ff}, 16'h0008);
    issue(dq(idmm_pkg::ACC_DIRECT, 8'h08, 8'h00), p0);
    chk({8'h00, drdata_ff}, 16'h0055);
    // a stack crossing into the upper half stays in ram
    sp_load = 1'b1;
    sp_wdata = 8'h7f;
    issue(d0, p0);
    sp_load = 1'b0;
    issue(dq(idmm_pkg::ACC_PUSH, 8'h00, 8'h66), p0);
    chk({7'h0, sfr_sel_ff, sp_ff}, 16'h0080);
    issue(dq(idmm_pkg::ACC_POP, 8'h00, 8'h00), p0);
    chk({drdata_ff, sp_ff}, 16'h667f);
    // program and xdata paths
    pq(idmm_pkg::PACC_MOVC, 16'h1234, 8'h00, 4'b1000);
    chk(flash_addr_ff, 16'h1234);
    chk({12'h000, f32}, 16'h0008);
    issue(d0, p0);
    chk({8'h00, prdata_ff}, 16'h006e);
    pq(idmm_pkg::PACC_MOVC, 16'hfbff, 8'h00, 4'b1010);
    chk({12'h000, f32}, 16'h0001);
    pq(idmm_pkg::PACC_MOVC, 16'h7fff, 8'h00, 4'b1000);
    chk({12'h000, f32}, 16'h000a);
    pq(idmm_pkg::PACC_MOVC, 16'h8000, 8'h00, 4'b1000);
    chk({12'h000, f32}, 16'h0001);
    pq(idmm_pkg::PACC_MOVC, 16'hfdff, 8'h00, 4'b1000);
    pq(idmm_pkg::PACC_MOVC, 16'hfe00, 8'h00, 4'b0001);
    pq(idmm_pkg::PACC_XWR, 16'h1abc, 8'h77, 4'b0000);
    pq(idmm_pkg::PACC_XRD, 16'h0abc, 8'h00, 4'b0000);
    chk({8'h00, prdata_ff}, 16'h0077);
    flash_wr_en = 1'b1;
    pq(idmm_pkg::PACC_XWR, 16'h0abc, 8'h11, 4'b0100);
    chk({8'h00, flash_wdata_ff}, 16'h0011);
    flash_wr_en = 1'b0;
    pq(idmm_pkg::PACC_XRD, 16'h0abc, 8'h00, 4'b0000);
    chk({8'h00, prdata_ff}, 16'h0077);
    // second reset in mid-run restores the pointer and clears ram
    reset_n = 1'b0;
    issue(d0, p0);
    chk({8'h00, sp_ff}, 16'h0007);
    reset_n = 1'b1;
    issue(dq(idmm_pkg::ACC_DIRECT, 8'h30, 8'h00), p0);
    chk({8'h00, drdata_ff}, 16'h0000);
    stop_test();
  end
endmodule : test_internal_data_memory_map
